// file: rtl/dpr_pkg.sv
package dpr_pkg;

  localparam int          DPR_MEM_BITS  = 4096;
  localparam int          DPR_ADDR_W    = 12;
  localparam int          DPR_DATA_W    = 16;
  localparam int          DPR_LW_W      = 3;

  // Port width codes: the code is log2 of the data width.
  localparam logic [2:0]  DPR_W1        = 3'h0;
  localparam logic [2:0]  DPR_W2        = 3'h1;
  localparam logic [2:0]  DPR_W4        = 3'h2;
  localparam logic [2:0]  DPR_W8        = 3'h3;
  localparam logic [2:0]  DPR_W16       = 3'h4;

  localparam logic [11:0] DPR_ADDR_FULL = 12'hFFF;
  localparam logic [15:0] DPR_RDATA_RST = 16'h0000;

endpackage

// file: rtl/dpr_block_ram.sv
`timescale 1ns/10ps
// Summary of operation
// - One 4096-bit array, accessed on clock edges.
// - Each port has its own control inputs.
// - Port widths set independently, enabling width conversion.
// - Width 1: 4096 locations, 12-bit address.
// - Width 2: 2048 locations, 11-bit address.
// - Width 4: 1024 locations, 10-bit address.
// - Width 8: 512 locations, 9-bit address.
// - Width 16: 256 locations, 8-bit address.
module dpr_block_ram (
  input  wire logic        clk_sys,
  input  wire logic        reset,
  input  wire logic        en_a,
  input  wire logic        we_a,
  input  wire logic [2:0]  width_a,
  input  wire logic [11:0] addr_a,
  input  wire logic [15:0] wdata_a,
  output logic      [15:0] rdata_a,
  input  wire logic        en_b,
  input  wire logic        we_b,
  input  wire logic [2:0]  width_b,
  input  wire logic [11:0] addr_b,
  input  wire logic [15:0] wdata_b,
  output logic      [15:0] rdata_b
);

  ////////////////////////////////////////////////////////////////////////////////////////////

  // Codes above the widest width are clamped to it, so no code can address outside the array.
  function automatic logic [2:0] dpr_lw(input logic [2:0] code);
    dpr_lw = (code > dpr_pkg::DPR_W16) ? dpr_pkg::DPR_W16 : code;
  endfunction

  function automatic logic [4:0] dpr_width(input logic [2:0] lw);
    dpr_width = 5'(5'h01 << lw);
  endfunction

  // Unused upper address bits are ignored; the base is the first array bit of the location.
  function automatic logic [11:0] dpr_base(input logic [11:0] addr, input logic [2:0] lw);
    logic [11:0] mask;
    mask     = dpr_pkg::DPR_ADDR_FULL >> lw;
    dpr_base = (addr & mask) << lw;
  endfunction

  function automatic logic [15:0] dpr_read(input logic [4095:0] arr,
                                           input logic [11:0]   base,
                                           input logic [2:0]    lw);
    logic [15:0] r;
    r = dpr_pkg::DPR_RDATA_RST;
    for (int i = 0; i < dpr_pkg::DPR_DATA_W; i++) begin
      if (5'(i) < dpr_width(lw)) begin
        r[i] = arr[12'(base + 12'(i))];
      end
    end
    dpr_read = r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////////////////

  logic [4095:0] mem;
  logic [2:0]    lw_a;
  logic [2:0]    lw_b;
  logic [11:0]   base_a;
  logic [11:0]   base_b;
  logic [15:0]   next_rdata_a;
  logic [15:0]   next_rdata_b;

  always_comb begin
    lw_a         = dpr_lw(width_a);
    lw_b         = dpr_lw(width_b);
    base_a       = dpr_base(addr_a, lw_a);
    base_b       = dpr_base(addr_b, lw_b);
    next_rdata_a = dpr_read(mem, base_a, lw_a);
    next_rdata_b = dpr_read(mem, base_b, lw_b);
  end

  // Contents have no reset, as in a real block memory. Port A is applied after port B at each offset,
  // so it wins a bit both ports write in one cycle unless port B's unit starts at a lower bit.
  always_ff @(posedge clk_sys) begin
    for (int i = 0; i < dpr_pkg::DPR_DATA_W; i++) begin
      if (en_b && we_b && (5'(i) < dpr_width(lw_b))) begin
        mem[12'(base_b + 12'(i))] <= wdata_b[i];
      end
      if (en_a && we_a && (5'(i) < dpr_width(lw_a))) begin
        mem[12'(base_a + 12'(i))] <= wdata_a[i];
      end
    end
  end

  // Reads return the contents before a same-edge write (read-first), a port holds its
  // last read data while disabled, and unused upper data bits read zero.
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      rdata_a <= dpr_pkg::DPR_RDATA_RST;
    end else if (en_a) begin
      rdata_a <= next_rdata_a;
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      rdata_b <= dpr_pkg::DPR_RDATA_RST;
    end else if (en_b) begin
      rdata_b <= next_rdata_b;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////////

  hold_idle_a: assert property (@(posedge clk_sys) disable iff (reset)
    !en_a |=> $stable(rdata_a)) else $error("Port A read data moved while disabled.");

  b_idle_hold_a: assert property (@(posedge clk_sys) disable iff (reset)
    !en_b |=> $stable(rdata_b)) else $error("Port B read data moved while disabled.");

  narrow_zero_a: assert property (@(posedge clk_sys) disable iff (reset)
    en_a && width_a == dpr_pkg::DPR_W1 |=> rdata_a[15:1] == 15'h0000)
    else $error("Port A one-bit read has nonzero upper bits.");

  b_byte_zero_a: assert property (@(posedge clk_sys) disable iff (reset)
    en_b && width_b == dpr_pkg::DPR_W8 |=> rdata_b[15:8] == 8'h00)
    else $error("Port B byte read has nonzero upper bits.");

  bit_read_a: assert property (@(posedge clk_sys) disable iff (reset)
    en_a && width_a == dpr_pkg::DPR_W1 |=> rdata_a[0] == $past(mem[addr_a]))
    else $error("Port A one-bit read returned the wrong bit.");

  b_nibble_read_a: assert property (@(posedge clk_sys) disable iff (reset)
    en_b && width_b == dpr_pkg::DPR_W4
    |=> rdata_b[3:0] === $past(mem[{addr_b[9:0], 2'h0} +: 4]))
    else $error("Port B nibble read returned the wrong bits.");

  word_write_a: assert property (@(posedge clk_sys) disable iff (reset)
    en_a && we_a && width_a == dpr_pkg::DPR_W16
    |=> mem[{$past(addr_a[7:0]), 4'h0} +: 16] == $past(wdata_a))
    else $error("Port A word write not stored.");

  b_pair_write_a: assert property (@(posedge clk_sys) disable iff (reset)
    en_b && we_b && width_b == dpr_pkg::DPR_W2 && !(en_a && we_a)
    |=> mem[{$past(addr_b[10:0]), 1'h0} +: 2] == $past(wdata_b[1:0]))
    else $error("Port B two-bit write not stored.");

  b_bit_zero_a: assert property (@(posedge clk_sys) disable iff (reset)
    en_b && width_b == dpr_pkg::DPR_W1
    |=> rdata_b[15:1] == 15'h0000)
    else $error("Port B one-bit read has nonzero upper bits.");

  b_pair_zero_a: assert property (@(posedge clk_sys) disable iff (reset)
    en_b && width_b == dpr_pkg::DPR_W2
    |=> rdata_b[15:2] == 14'h0000)
    else $error("Port B two-bit read has nonzero upper bits.");

  b_nibble_zero_a: assert property (@(posedge clk_sys) disable iff (reset)
    en_b && width_b == dpr_pkg::DPR_W4
    |=> rdata_b[15:4] == 12'h000)
    else $error("Port B nibble read has nonzero upper bits.");

  // Read checks use case equality, since bits that were never written hold no defined value.
  a_word_read_a: assert property (@(posedge clk_sys) disable iff (reset)
    en_a && width_a == dpr_pkg::DPR_W16
    |=> rdata_a === $past(mem[{addr_a[7:0], 4'h0} +: 16]))
    else $error("Port A word read returned the wrong bits.");

  a_clamp_read_a: assert property (@(posedge clk_sys) disable iff (reset)
    en_a && width_a > dpr_pkg::DPR_W16
    |=> rdata_a === $past(mem[{addr_a[7:0], 4'h0} +: 16]))
    else $error("Port A oversized width code did not act as a word.");

  a_read_first_a: assert property (@(posedge clk_sys) disable iff (reset)
    en_a && we_a && width_a == dpr_pkg::DPR_W16
    |=> rdata_a === $past(mem[{addr_a[7:0], 4'h0} +: 16]))
    else $error("Port A write did not return the old word.");

  b_bit_read_a: assert property (@(posedge clk_sys) disable iff (reset)
    en_b && width_b == dpr_pkg::DPR_W1
    |=> rdata_b[0] === $past(mem[addr_b]))
    else $error("Port B one-bit read returned the wrong bit.");

  b_pair_read_a: assert property (@(posedge clk_sys) disable iff (reset)
    en_b && width_b == dpr_pkg::DPR_W2
    |=> rdata_b[1:0] === $past(mem[{addr_b[10:0], 1'h0} +: 2]))
    else $error("Port B two-bit read returned the wrong bits.");

  b_byte_read_a: assert property (@(posedge clk_sys) disable iff (reset)
    en_b && width_b == dpr_pkg::DPR_W8
    |=> rdata_b[7:0] === $past(mem[{addr_b[8:0], 3'h0} +: 8]))
    else $error("Port B byte read returned the wrong bits.");

  b_word_read_a: assert property (@(posedge clk_sys) disable iff (reset)
    en_b && width_b == dpr_pkg::DPR_W16
    |=> rdata_b === $past(mem[{addr_b[7:0], 4'h0} +: 16]))
    else $error("Port B word read returned the wrong bits.");

  // Port B write checks skip cycles in which port A writes too, because port A wins a bit both write unless port B's unit starts lower.
  b_bit_write_a: assert property (@(posedge clk_sys) disable iff (reset)
    en_b && we_b && width_b == dpr_pkg::DPR_W1 && !(en_a && we_a)
    |=> mem[$past(addr_b)] == $past(wdata_b[0]))
    else $error("Port B one-bit write not stored.");

  b_nibble_write_a: assert property (@(posedge clk_sys) disable iff (reset)
    en_b && we_b && width_b == dpr_pkg::DPR_W4 && !(en_a && we_a)
    |=> mem[{$past(addr_b[9:0]), 2'h0} +: 4] == $past(wdata_b[3:0]))
    else $error("Port B nibble write not stored.");

  b_byte_write_a: assert property (@(posedge clk_sys) disable iff (reset)
    en_b && we_b && width_b == dpr_pkg::DPR_W8 && !(en_a && we_a)
    |=> mem[{$past(addr_b[8:0]), 3'h0} +: 8] == $past(wdata_b[7:0]))
    else $error("Port B byte write not stored.");

  b_word_write_a: assert property (@(posedge clk_sys) disable iff (reset)
    en_b && we_b && width_b == dpr_pkg::DPR_W16 && !(en_a && we_a)
    |=> mem[{$past(addr_b[7:0]), 4'h0} +: 16] == $past(wdata_b))
    else $error("Port B word write not stored.");

  cross_width_a: assert property (@(posedge clk_sys) disable iff (reset)
    (en_a && we_a && width_a == dpr_pkg::DPR_W16) ##1
    (!(en_a && we_a) && !(en_b && we_b)) ##1
    (en_b && !we_b && width_b == dpr_pkg::DPR_W1 && !(en_a && we_a) &&
     addr_b[11:4] == $past(addr_a[7:0], 2))
    |=> rdata_b[0] == 1'($past(wdata_a, 3) >> $past(addr_b[3:0])))
    else $error("Width conversion from port A to port B mismatched.");

endmodule // dpr_block_ram

// file: verif/dpr_client.sv
`timescale 1ns/10ps
// One user-logic client of a memory port; it changes its lines only at the falling edge.
module dpr_client (
  input  wire logic        clk_sys,
  output logic             en,
  output logic             we,
  output logic      [2:0]  width,
  output logic      [11:0] addr,
  output logic      [15:0] wdata,
  input  wire logic [15:0] rdata
);
  initial {en, we, width, addr, wdata} = '0;
  ////////////////////////////////////////////////////////////////////////////////
  // Stale write data is inverted on release so that it cannot pass for a hold.
  task automatic access(input logic w, input logic [2:0] c, input logic [11:0] a,
                        input logic [15:0] d, output logic [15:0] q);
    @(negedge clk_sys);
    {en, we, width, addr, wdata} = {1'b1, w, c, a, d};
    @(negedge clk_sys);
    {en, wdata} = {1'b0, ~d};
    q = rdata;
  endtask
endmodule // dpr_client

// file: verif/test_dual_port_block_ram.sv
`timescale 1ns/10ps
`define CHK(n, e, g) begin n_compared++; if ((g) !== (e)) begin \
  $display("ERROR %s expected %h seen %h", n, e, g); mismatches++; end end
module test_dual_port_block_ram;
  logic        clk_sys;
  logic        reset;
  logic        en_a, we_a, en_b, we_b;
  logic [2:0]  width_a, width_b;
  logic [11:0] addr_a, addr_b;
  logic [15:0] wdata_a, wdata_b, rdata_a, rdata_b, q, keep;
  int          mismatches = 0;
  int          n_compared = 0;
  dpr_block_ram i_dut (.clk_sys, .reset, .en_a, .we_a, .width_a, .addr_a, .wdata_a,
                       .rdata_a, .en_b, .we_b, .width_b, .addr_b, .wdata_b, .rdata_b);
  dpr_client i_cli_a (.clk_sys, .en(en_a), .we(we_a), .width(width_a), .addr(addr_a),
                      .wdata(wdata_a), .rdata(rdata_a));
  dpr_client i_cli_b (.clk_sys, .en(en_b), .we(we_b), .width(width_b), .addr(addr_b),
                      .wdata(wdata_b), .rdata(rdata_b));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic wrap_up();
    if (mismatches == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic wide_to_narrow();
    i_cli_a.access(1'b1, dpr_pkg::DPR_W16, 12'h005, 16'hA5C3, q);
    for (int b = 0; b < 16; b++) begin
      i_cli_b.access(1'b0, dpr_pkg::DPR_W1, 12'h050 + 12'(b), 16'h0000, q);
      `CHK("narrow bit", 16'((16'hA5C3 >> b) & 16'h0001), q)
    end
  endtask
  // The word is cleared first because memory holds no known value after reset.
  task automatic narrow_to_wide();
    for (int k = 0; k < 4; k++) begin
      i_cli_a.access(1'b1, dpr_pkg::DPR_W16, 12'h020, 16'h0000, q);
      i_cli_b.access(1'b1, 3'(k), 12'(512 >> k) + 12'h001, 16'hFFFF, q);
      `CHK("old unit", 16'h0000, q)
      keep = rdata_b;
      i_cli_a.access(1'b0, dpr_pkg::DPR_W16, 12'h020, 16'h0000, q);
      `CHK("wide word", 16'(((1 << (1 << k)) - 1) << (1 << k)), q)
      `CHK("idle port", keep, rdata_b)
    end
    i_cli_a.access(1'b0, 3'h7, 12'h020, 16'h0000, q);
    `CHK("clamped word", 16'hFF00, q)
  endtask
  task automatic top_corner();
    for (int k = 0; k < 5; k++) begin
      i_cli_b.access(1'b1, 3'(k), dpr_pkg::DPR_ADDR_FULL >> k, {16{k[0]}}, q);
      i_cli_a.access(1'b0, dpr_pkg::DPR_W1, dpr_pkg::DPR_ADDR_FULL, 16'h0000, q);
      `CHK("top bit", {15'h0000, k[0]}, q)
    end
  endtask
  // Both ports write one word at the same edge; each sees the old word and port A wins.
  task automatic both_ports();
    i_cli_a.access(1'b1, dpr_pkg::DPR_W16, 12'h030, 16'h0F0F, q);
    fork
      i_cli_a.access(1'b1, dpr_pkg::DPR_W16, 12'h030, 16'h5A3C, q);
      i_cli_b.access(1'b1, dpr_pkg::DPR_W16, 12'h030, 16'hFFFF, keep);
    join
    `CHK("old word a", 16'h0F0F, q)
    `CHK("old word b", 16'h0F0F, keep)
    i_cli_b.access(1'b0, dpr_pkg::DPR_W16, 12'h030, 16'h0000, q);
    `CHK("shared word", 16'h5A3C, q)
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  initial begin
    reset = 1'b1;
    repeat (10) @(negedge clk_sys);
    reset = 1'b0;
    wide_to_narrow();
    narrow_to_wide();
    top_corner();
    both_ports();
    wrap_up();
  end
endmodule // test_dual_port_block_ram
